//--- design/ssf_consts.svh
// register map, field positions and reset values of the serial status block
`ifndef SSF_CONSTS_SVH
`define SSF_CONSTS_SVH
// ==========================================================
// byte addresses
`define SSF_ADDR_STATUS     32'hffff_0a00
`define SSF_ADDR_CONTROL    32'hffff_0a04
`define SSF_ADDR_RXDATA     32'hffff_0a08
`define SSF_ADDR_TXDATA     32'hffff_0a0c
`define SSF_ADDR_IRQ_STATUS 32'hffff_0a10
`define SSF_ADDR_IRQ_CLEAR  32'hffff_0a14
`define SSF_ADDR_IRQ_ENABLE 32'hffff_0a18
// ==========================================================
// serial_status fields
`define SSF_ST_EXCESS 11
`define SSF_ST_RXCNT  8
`define SSF_ST_OVF    7
`define SSF_ST_RXIRQ  6
`define SSF_ST_TXIRQ  5
`define SSF_ST_UNF    4
`define SSF_ST_TXCNT  1
`define SSF_ST_ANY    0
// ==========================================================
// serial_control fields
`define SSF_CT_THR    0
`define SSF_CT_ROLE   3
`define SSF_CT_IMODE  6
`define SSF_CT_OVFMSK 12
`define SSF_CT_UNFMSK 13
`define SSF_CT_WMASK  16'h304f
// ==========================================================
// interrupt register bits
`define SSF_IQ_OVF    0
`define SSF_IQ_RXIRQ  1
`define SSF_IQ_TXIRQ  2
`define SSF_IQ_UNF    3
// ==========================================================
// reset values and responses
`define SSF_STATUS_RST  16'h0000
`define SSF_CONTROL_RST 16'h0000
`define SSF_IRQ_RST     4'h0
`define SSF_RESP_OKAY   2'h0
`define SSF_RESP_SLVERR 2'h2
`endif

//--- design/ssf_link.sv
// serial shift engine, pins sampled on the core clock
module ssf_link (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // serial pins
    input  wire logic               spi_sclk,
    input  wire logic               spi_cs_n,
    input  wire logic               spi_mosi,
    output logic                    spi_miso_o,
    output logic                    spi_miso_oe,
    // byte side
    output logic                    tx_req,
    input  wire ssf_pkg::ssf_byte_t tx_data,
    output logic                    rx_valid,
    output ssf_pkg::ssf_byte_t      rx_data,
    output logic                    tx_done
);
    import ssf_pkg::*;

    // ==========================================================
    // synchronisers
    logic         sclk_s1, sclk_s2, sclk_s3;
    logic         cs_s1, cs_s2;
    logic         mosi_s1, mosi_s2;
    ssf_link_st_t st, next_st;
    logic [2:0]   bitcnt, next_bitcnt;
    ssf_byte_t    rx_sh, next_rx_sh;
    ssf_byte_t    tx_sh, next_tx_sh;
    ssf_byte_t    next_rx_data;
    logic         next_rx_valid, next_tx_done;
    logic         rise, fall, active;

    assign rise        = sclk_s2 & ~sclk_s3;
    assign fall        = ~sclk_s2 & sclk_s3;
    assign active      = ~cs_s2;
    assign spi_miso_o  = tx_sh[7];
    assign spi_miso_oe = active;

    // ==========================================================
    // shift control, mode 0: sample on rise, shift on fall
    always_comb
    begin
        next_st       = st;
        next_bitcnt   = bitcnt;
        next_rx_sh    = rx_sh;
        next_tx_sh    = tx_sh;
        next_rx_data  = rx_data;
        next_rx_valid = 1'b0;
        next_tx_done  = 1'b0;
        tx_req        = 1'b0;
        unique case (st)
            SSF_IDLE:
            begin
                if (active)
                begin
                    next_st     = SSF_SHIFT;
                    tx_req      = 1'b1;
                    next_tx_sh  = tx_data;
                    next_bitcnt = 3'h0;
                end
            end
            SSF_SHIFT:
            begin
                if (!active)
                    next_st = SSF_IDLE;
                else if (rise)
                begin
                    next_rx_sh  = {rx_sh[6:0], mosi_s2};
                    next_bitcnt = bitcnt + 3'h1;
                    if (bitcnt == 3'h7)
                    begin
                        // next byte is fetched now, so a frame end also pops one
                        next_rx_valid = 1'b1;
                        next_rx_data  = {rx_sh[6:0], mosi_s2};
                        next_tx_done  = 1'b1;
                        tx_req        = 1'b1;
                        next_tx_sh    = tx_data;
                    end
                end
                else if (fall && bitcnt != 3'h0)
                    next_tx_sh = {tx_sh[6:0], 1'b0};
            end
            default:
                next_st = SSF_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sclk_s1  <= 1'b0;
            sclk_s2  <= 1'b0;
            sclk_s3  <= 1'b0;
            cs_s1    <= 1'b1;
            cs_s2    <= 1'b1;
            mosi_s1  <= 1'b0;
            mosi_s2  <= 1'b0;
            st       <= SSF_IDLE;
            bitcnt   <= 3'h0;
            rx_sh    <= 8'h00;
            tx_sh    <= 8'h00;
            rx_data  <= 8'h00;
            rx_valid <= 1'b0;
            tx_done  <= 1'b0;
        end
        else
        begin
            sclk_s1  <= spi_sclk;
            sclk_s2  <= sclk_s1;
            sclk_s3  <= sclk_s2;
            cs_s1    <= spi_cs_n;
            cs_s2    <= cs_s1;
            mosi_s1  <= spi_mosi;
            mosi_s2  <= mosi_s1;
            st       <= next_st;
            bitcnt   <= next_bitcnt;
            rx_sh    <= next_rx_sh;
            tx_sh    <= next_tx_sh;
            rx_data  <= next_rx_data;
            rx_valid <= next_rx_valid;
            tx_done  <= next_tx_done;
        end
    end
endmodule

//--- design/ssf_pkg.sv
// types shared by the serial status block
package ssf_pkg;
    typedef logic [7:0] ssf_byte_t;
    typedef enum logic [1:0] {
        SSF_IDLE  = 2'h0,
        SSF_SHIFT = 2'h1
    } ssf_link_st_t;
endpackage

//--- design/ssf_top.sv
// serial interface with byte fifos, status flags, interrupts and axi4-lite registers
`include "ssf_consts.svh"
module ssf_top #(
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // axi4-lite write
    input  wire logic [31:0]        s_axi_awaddr,
    input  wire logic [2:0]         s_axi_awprot,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // axi4-lite read
    input  wire logic [31:0]        s_axi_araddr,
    input  wire logic [2:0]         s_axi_arprot,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // serial pins
    input  wire logic               spi_sclk,
    input  wire logic               spi_cs_n,
    input  wire logic               spi_mosi,
    output logic                    spi_miso_o,
    output logic                    spi_miso_oe,
    // interrupt
    output logic                    irq
);
    import ssf_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
        hit = (a == off);
    endfunction

    function automatic logic mapped(input logic [31:0] a);
        mapped = hit(a, `SSF_ADDR_STATUS) | hit(a, `SSF_ADDR_CONTROL) |
                 hit(a, `SSF_ADDR_RXDATA) | hit(a, `SSF_ADDR_TXDATA) |
                 hit(a, `SSF_ADDR_IRQ_STATUS) | hit(a, `SSF_ADDR_IRQ_CLEAR) |
                 hit(a, `SSF_ADDR_IRQ_ENABLE);
    endfunction

    // ==========================================================
    // state
    ssf_byte_t         rx_mem [DEPTH];
    ssf_byte_t         tx_mem [DEPTH];
    logic [PW-1:0]     rx_wp, rx_rp, tx_wp, tx_rp;
    logic [PW-1:0]     next_rx_wp, next_rx_rp, next_tx_wp, next_tx_rp;
    logic [CW-1:0]     rx_cnt, tx_cnt, next_rx_cnt, next_tx_cnt;
    logic [2:0]        rx_seen, tx_seen, next_rx_seen, next_tx_seen;
    logic              ovf, rxi, txi, unf, anyi;
    logic              next_ovf, next_rxi, next_txi, next_unf, next_anyi;
    logic [15:0]       ctrl, next_ctrl;
    logic [3:0]        iq_sts, iq_en, next_iq_sts, next_iq_en;
    logic              aw_full, w_full, next_aw_full, next_w_full;
    logic [31:0]       aw_addr, w_data, next_aw_addr, next_w_data;
    logic [3:0]        w_strb, next_w_strb;
    logic              next_bvalid, next_rvalid;
    logic [1:0]        next_bresp, next_rresp;
    logic [31:0]       next_rdata;

    // ==========================================================
    // link and event wiring
    logic              tx_req, rx_valid, tx_done;
    ssf_byte_t         rx_byte, tx_head;
    logic              rx_full, tx_empty, do_wr, do_rd, rd_status;
    logic              rx_push, rx_pop, tx_push, tx_pop;
    logic              ovf_ev, unf_ev, rxi_ev, txi_ev, any_ev;
    logic [2:0]        thr_eff;
    logic [15:0]       status_val, be_mask;

    ssf_link u_link (
        .clk         (clk),
        .rst_n       (rst_n),
        .spi_sclk    (spi_sclk),
        .spi_cs_n    (spi_cs_n),
        .spi_mosi    (spi_mosi),
        .spi_miso_o  (spi_miso_o),
        .spi_miso_oe (spi_miso_oe),
        .tx_req      (tx_req),
        .tx_data     (tx_head),
        .rx_valid    (rx_valid),
        .rx_data     (rx_byte),
        .tx_done     (tx_done)
    );

    assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_full & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign do_wr         = aw_full & w_full & ~s_axi_bvalid;
    assign do_rd         = s_axi_arvalid & ~s_axi_rvalid;
    assign rd_status     = do_rd & hit(s_axi_araddr, `SSF_ADDR_STATUS);

    assign rx_full  = (rx_cnt == CW'(DEPTH));
    assign tx_empty = (tx_cnt == '0);
    assign tx_head  = tx_empty ? 8'h00 : tx_mem[tx_rp];
    assign rx_pop   = do_rd & hit(s_axi_araddr, `SSF_ADDR_RXDATA) & (rx_cnt != '0);
    // a pop in the same cycle frees the slot, so that byte is kept
    assign ovf_ev   = rx_valid & rx_full & ~rx_pop;
    assign rx_push  = rx_valid & ~ovf_ev;
    assign tx_push  = do_wr & hit(aw_addr, `SSF_ADDR_TXDATA) & w_strb[0] & (tx_cnt != CW'(DEPTH));
    assign tx_pop   = tx_req & ~tx_empty;
    assign unf_ev   = tx_req & tx_empty;
    // threshold zero is taken as one byte, so the counters never stall
    assign thr_eff  = (ctrl[`SSF_CT_THR +: 3] == 3'h0) ? 3'h1 : ctrl[`SSF_CT_THR +: 3];
    // role bit is stored only; nothing below reads it
    // at or above, so a threshold lowered mid count still fires
    assign rxi_ev   = ~ctrl[`SSF_CT_IMODE] & rx_push & (rx_seen + 3'h1 >= thr_eff);
    assign txi_ev   = ctrl[`SSF_CT_IMODE] & tx_done & (tx_seen + 3'h1 >= thr_eff);
    assign any_ev   = (ovf_ev & ~ctrl[`SSF_CT_OVFMSK]) | (unf_ev & ~ctrl[`SSF_CT_UNFMSK]) |
                      rxi_ev | txi_ev;

    // reserved bits tied to zero
    assign status_val = {4'h0,
                         (rx_cnt > CW'(ctrl[`SSF_CT_THR +: 3])),
                         3'(rx_cnt),
                         ovf, rxi, txi, unf,
                         3'(tx_cnt),
                         anyi};
    assign be_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
    assign irq     = |(iq_sts & iq_en);

    // ==========================================================
    // next state
    always_comb
    begin
        next_rx_wp   = rx_wp;
        next_rx_rp   = rx_rp;
        next_tx_wp   = tx_wp;
        next_tx_rp   = tx_rp;
        next_rx_cnt  = rx_cnt;
        next_tx_cnt  = tx_cnt;
        next_rx_seen = rx_seen;
        next_tx_seen = tx_seen;
        next_ctrl    = ctrl;
        next_iq_en   = iq_en;
        next_iq_sts  = iq_sts;
        next_aw_full = aw_full;
        next_w_full  = w_full;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid;
        next_rresp   = s_axi_rresp;
        next_rdata   = s_axi_rdata;

        // fifo pointers and counts
        if (rx_push)
            next_rx_wp = rx_wp + PW'(1);
        if (rx_pop)
            next_rx_rp = rx_rp + PW'(1);
        next_rx_cnt = rx_cnt + CW'(rx_push) - CW'(rx_pop);
        if (tx_push)
            next_tx_wp = tx_wp + PW'(1);
        if (tx_pop)
            next_tx_rp = tx_rp + PW'(1);
        next_tx_cnt = tx_cnt + CW'(tx_push) - CW'(tx_pop);
        // each counter runs only in its own mode, so it cannot drift past the threshold
        if (rx_push && !ctrl[`SSF_CT_IMODE])
            next_rx_seen = rxi_ev ? 3'h0 : rx_seen + 3'h1;
        if (tx_done && ctrl[`SSF_CT_IMODE])
            next_tx_seen = txi_ev ? 3'h0 : tx_seen + 3'h1;

        // status read clears, a same-cycle event wins
        next_ovf  = ovf_ev | (ovf & ~rd_status);
        next_rxi  = rxi_ev | (rxi & ~rd_status);
        next_txi  = txi_ev | (txi & ~rd_status);
        next_unf  = unf_ev | (unf & ~rd_status);
        next_anyi = any_ev | (anyi & ~rd_status);

        // write channel capture, either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_wr)
        begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = mapped(aw_addr) ? `SSF_RESP_OKAY : `SSF_RESP_SLVERR;
            if (hit(aw_addr, `SSF_ADDR_CONTROL))
                next_ctrl = (ctrl & ~(be_mask & `SSF_CT_WMASK)) |
                            (w_data[15:0] & be_mask & `SSF_CT_WMASK);
            if (hit(aw_addr, `SSF_ADDR_IRQ_ENABLE) && w_strb[0])
                next_iq_en = w_data[3:0];
            if (hit(aw_addr, `SSF_ADDR_IRQ_CLEAR) && w_strb[0])
                next_iq_sts = iq_sts & ~w_data[3:0];
        end
        else if (s_axi_bvalid && s_axi_bready)
            next_bvalid = 1'b0;

        // interrupt causes set after the clear so they win
        next_iq_sts[`SSF_IQ_OVF]   = next_iq_sts[`SSF_IQ_OVF] | (ovf_ev & ~ctrl[`SSF_CT_OVFMSK]);
        next_iq_sts[`SSF_IQ_UNF]   = next_iq_sts[`SSF_IQ_UNF] | (unf_ev & ~ctrl[`SSF_CT_UNFMSK]);
        next_iq_sts[`SSF_IQ_RXIRQ] = next_iq_sts[`SSF_IQ_RXIRQ] | rxi_ev;
        next_iq_sts[`SSF_IQ_TXIRQ] = next_iq_sts[`SSF_IQ_TXIRQ] | txi_ev;

        // read channel, data registered one cycle after the address
        if (do_rd)
        begin
            next_rvalid = 1'b1;
            next_rresp  = mapped(s_axi_araddr) ? `SSF_RESP_OKAY : `SSF_RESP_SLVERR;
            next_rdata  = 32'h0000_0000;
            if (hit(s_axi_araddr, `SSF_ADDR_STATUS))
                next_rdata = {16'h0000, status_val};
            else if (hit(s_axi_araddr, `SSF_ADDR_CONTROL))
                next_rdata = {16'h0000, ctrl};
            else if (hit(s_axi_araddr, `SSF_ADDR_RXDATA))
                next_rdata = {24'h00_0000, (rx_cnt != '0) ? rx_mem[rx_rp] : 8'h00};
            else if (hit(s_axi_araddr, `SSF_ADDR_IRQ_STATUS))
                next_rdata = {28'h000_0000, iq_sts};
            else if (hit(s_axi_araddr, `SSF_ADDR_IRQ_ENABLE))
                next_rdata = {28'h000_0000, iq_en};
        end
        else if (s_axi_rvalid && s_axi_rready)
            next_rvalid = 1'b0;
    end

    // ==========================================================
    // registers; a write to the status address lands nowhere
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rx_wp        <= '0;
            rx_rp        <= '0;
            tx_wp        <= '0;
            tx_rp        <= '0;
            rx_cnt       <= '0;
            tx_cnt       <= '0;
            rx_seen      <= 3'h0;
            tx_seen      <= 3'h0;
            {ovf, rxi, txi, unf, anyi} <= 5'h00;
            ctrl         <= `SSF_CONTROL_RST;
            iq_sts       <= `SSF_IRQ_RST;
            iq_en        <= `SSF_IRQ_RST;
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            aw_addr      <= 32'h0000_0000;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SSF_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `SSF_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end
        else
        begin
            rx_wp        <= next_rx_wp;
            rx_rp        <= next_rx_rp;
            tx_wp        <= next_tx_wp;
            tx_rp        <= next_tx_rp;
            rx_cnt       <= next_rx_cnt;
            tx_cnt       <= next_tx_cnt;
            rx_seen      <= next_rx_seen;
            tx_seen      <= next_tx_seen;
            {ovf, rxi, txi, unf, anyi} <= {next_ovf, next_rxi, next_txi, next_unf, next_anyi};
            ctrl         <= next_ctrl;
            iq_sts       <= next_iq_sts;
            iq_en        <= next_iq_en;
            aw_full      <= next_aw_full;
            w_full       <= next_w_full;
            aw_addr      <= next_aw_addr;
            w_data       <= next_w_data;
            w_strb       <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp  <= next_rresp;
            s_axi_rdata  <= next_rdata;
        end
    end

    // fifo storage has no reset; counts guard every read
    always_ff @(posedge clk)
    begin
        if (rx_push)
            rx_mem[rx_wp] <= rx_byte;
        if (tx_push)
            tx_mem[tx_wp] <= w_data[7:0];
    end
endmodule

//--- dv/ssf_checker.sv
// port-level assertions for the serial status block
`include "ssf_consts.svh"
module ssf_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // register bus
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    // serial pins
    input wire logic        spi_cs_n,
    input wire logic        spi_miso_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic st_rd;
    logic wr_go;
    assign st_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == `SSF_ADDR_STATUS;
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // register bus
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
    chk_write_answer: assert property (wr_go |-> !s_axi_bvalid ##2 s_axi_bvalid)
        else $error("write response not two cycles after handshake");
    chk_bus_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels open while response pending");
    chk_status_write: assert property (wr_go && s_axi_awaddr == `SSF_ADDR_STATUS |-> ##2 s_axi_bresp == 2'h0)
        else $error("status write not acknowledged okay");
    chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'hffff_0a1c
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read not refused");
    // ==========================================================
    // status contents
    chk_rsv_zero: assert property (st_rd |=> s_axi_rdata[31:12] == 20'h0_0000 && s_axi_rresp == 2'h0)
        else $error("status reserved bits not zero");
    chk_count_range: assert property (st_rd |=> s_axi_rdata[10:8] <= 3'h4 && s_axi_rdata[3:1] <= 3'h4)
        else $error("fifo count out of range");
    // ==========================================================
    // serial pins: output only driven inside a frame
    chk_oe_idle: assert property (spi_cs_n [*5] |-> !spi_miso_oe)
        else $error("miso driven while deselected");
    chk_oe_start: assert property ($fell(spi_cs_n) |-> ##[2:5] spi_miso_oe)
        else $error("miso not driven after select");
endmodule

//--- dv/ssf_spi_master.sv
// behavioural serial master, mode 0, msb first, 125 ns bit time
module ssf_spi_master (
    // serial pins
    output logic            spi_sclk,
    output logic            spi_cs_n,
    output logic            spi_mosi,
    input  wire logic       spi_miso_o,
    input  wire logic       spi_miso_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    ssf_pkg::ssf_byte_t got_q[$];
    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // sends n bytes base, base+1, ...; clock stands still outside frames
    task automatic frame(input int n, input ssf_pkg::ssf_byte_t base);
        ssf_pkg::ssf_byte_t r;
        ssf_pkg::ssf_byte_t t;
        r = 8'h00;
        // pins move off the core clock edge
        #2 spi_cs_n = 1'b0;
        #100;
        for (int i = 0; i < n; i++)
        begin
            t = base + 8'(i);
            for (int b = 7; b >= 0; b--)
            begin
                spi_mosi = t[b];
                #62.5 spi_sclk = 1'b1;
                // an undriven miso would read as zero here, so a missing enable shows up
                r = {r[6:0], spi_miso_oe & spi_miso_o};
                #62.5 spi_sclk = 1'b0;
            end
            got_q.push_back(r);
        end
        #62.5 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
    endtask
endmodule

//--- dv/ssf_tb_top.sv
// self-checking bench for the serial status block
`include "ssf_consts.svh"
module ssf_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [1:0] bresp, rresp;
    logic sclk, cs_n, mosi, miso, miso_oe, irq, bready, rready;
    logic [3:0] wstrb;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    ssf_top #(.DEPTH(4)) u_dut (.clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso_o(miso), .spi_miso_oe(miso_oe), .irq(irq));
    ssf_spi_master u_spi (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso_o(miso), .spi_miso_oe(miso_oe));
    // ==========================================================
    // checks and bus tasks; tasks start and end just after a rising edge
    task automatic final_report();
        if (num_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        @(posedge clk);
        check_val({30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        @(posedge clk);
        check_val(d, exp);
        check_val({30'h0, r}, {30'h0, er});
    endtask
    // ==========================================================
    // clock, reset, timeout
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        // the whole run needs about 740 cycles
        if (cycles == 20000)
        begin
            num_errors++;
            final_report();
        end
    end
    // ==========================================================
    // scenarios
    initial
    begin
        {rst_n, awvalid, wvalid, arvalid, bready, rready, awaddr, wdata, araddr} = '0;
        wstrb = 4'hf;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(`SSF_ADDR_STATUS, 32'h0000_0000, 2'h0);
        wr(`SSF_ADDR_STATUS, 32'h0000_ffff, 2'h0);
        rd(`SSF_ADDR_STATUS, 32'h0000_0000, 2'h0);
        rd(32'hffff_0a1c, 32'h0000_0000, 2'h2);
        wr(`SSF_ADDR_CONTROL, 32'h0000_0001, 2'h0);
        wr(`SSF_ADDR_IRQ_ENABLE, 32'h0000_000f, 2'h0);
        wr(`SSF_ADDR_TXDATA, 32'h0000_005a, 2'h0);
        wr(`SSF_ADDR_TXDATA, 32'h0000_00c3, 2'h0);
        rd(`SSF_ADDR_STATUS, 32'h0000_0004, 2'h0);
        // five bytes into a four-deep fifo, two queued to send: overflow and underflow
        u_spi.frame(5, 8'ha0);
        repeat (10) @(posedge clk);
        check_val({24'h0, u_spi.got_q[0]}, 32'h0000_005a);
        check_val({24'h0, u_spi.got_q[1]}, 32'h0000_00c3);
        check_val({31'h0, irq}, 32'h0000_0001);
        rd(`SSF_ADDR_STATUS, 32'h0000_0cd1, 2'h0);
        rd(`SSF_ADDR_STATUS, 32'h0000_0c00, 2'h0);
        rd(`SSF_ADDR_IRQ_STATUS, 32'h0000_000b, 2'h0);
        wr(`SSF_ADDR_IRQ_CLEAR, 32'h0000_000f, 2'h0);
        check_val({31'h0, irq}, 32'h0000_0000);
        // lane 0 off: the byte is dropped, so the tx count read below stays zero
        wstrb <= 4'he;
        wr(`SSF_ADDR_TXDATA, 32'h0000_0077, 2'h0);
        wstrb <= 4'hf;
        for (int i = 0; i < 3; i++)
            rd(`SSF_ADDR_RXDATA, 32'h0000_00a0 + i, 2'h0);
        rd(`SSF_ADDR_STATUS, 32'h0000_0100, 2'h0);
        rd(`SSF_ADDR_RXDATA, 32'h0000_00a3, 2'h0);
        // other role, transmit interrupt mode, both fault masks set
        wr(`SSF_ADDR_CONTROL, 32'h0000_3048, 2'h0);
        wr(`SSF_ADDR_TXDATA, 32'h0000_0096, 2'h0);
        u_spi.frame(1, 8'h3c);
        repeat (10) @(posedge clk);
        check_val({24'h0, u_spi.got_q[5]}, 32'h0000_0096);
        rd(`SSF_ADDR_STATUS, 32'h0000_0931, 2'h0);
        rd(`SSF_ADDR_IRQ_STATUS, 32'h0000_0004, 2'h0);
        check_val({31'h0, irq}, 32'h0000_0001);
        final_report();
    end
endmodule
bind ssf_top ssf_checker u_chk (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe));
